// File: ptb_defs.svh
// register offsets, field positions, reset values and the maximum count value for the time-base counter
`ifndef PTB_DEFS_SVH
`define PTB_DEFS_SVH

// ==========================================================================
// register byte offsets
`define PTB_OFS_CONTROL    12'h000
`define PTB_OFS_STATUS     12'h004
`define PTB_OFS_PHASE      12'h008
`define PTB_OFS_COUNT      12'h00C
`define PTB_OFS_PERIOD     12'h010
`define PTB_OFS_GATE       12'h014

// ==========================================================================
// control register fields
`define PTB_CTL_MODE_LSB   0
`define PTB_CTL_MODE_MSB   1
`define PTB_CTL_PHEN_BIT   2
`define PTB_CTL_PERIOD_LOAD_SELECT_BIT  3
`define PTB_CTL_SWSYNC_BIT 6
`define PTB_CTL_SYNCO_BIT  7
`define PTB_CTL_PSC_LSB    8
`define PTB_CTL_PSC_MSB    15
`define PTB_CTL_DIR_BIT    5

// ==========================================================================
// status register fields
`define PTB_STS_DIR_BIT    0
`define PTB_STS_MAX_BIT    1
`define PTB_STS_ZERO_BIT   2
`define PTB_STS_PRD_BIT    3

// ==========================================================================
// reset values
`define PTB_CTL_RESET      32'h0000_0003
`define PTB_PERIOD_RESET   16'h0000
`define PTB_PHASE_RESET    16'h0000
`define PTB_COUNT_MAX      16'hFFFF

`endif

// File: ptb_pkg.sv
// types shared by the time-base counter files
package ptb_pkg;

	// ==========================================================================
	// count modes
	typedef enum logic [1:0] {
		PTB_MODE_UP     = 2'b00,
		PTB_MODE_DOWN   = 2'b01,
		PTB_MODE_UPDOWN = 2'b10,
		PTB_MODE_FREEZE = 2'b11
	} ptb_mode_t;

endpackage

// File: ptb_prescaler.sv
// prescaler giving one time-base tick per programmed value plus one system clocks
`timescale 1ns/1ps
module ptb_prescaler #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             run,
	input  wire logic [WIDTH-1:0] divide_minus_one,
	output logic                  tick
);
	import ptb_pkg::*;

	logic [WIDTH-1:0] div_count;
	logic [WIDTH-1:0] next_div_count;
	wire              wrap = (div_count >= divide_minus_one);

	// ==========================================================================
	// divider, held at zero while the gate is closed so edges align on start
	assign next_div_count = !run ? {WIDTH{1'b0}} : (wrap ? {WIDTH{1'b0}} : div_count + 1'b1);
	assign tick           = run && wrap;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_count <= '0;
		end else begin
			div_count <= next_div_count;
		end
	end

endmodule

// File: ptb_sync_peer.sv
// upstream module on the sync chain sending one sync pulse per request
`timescale 1ns/1ps
module ptb_sync_peer (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       fire,
	input  wire logic [3:0] delay,
	output logic            sync_pulse
);
	logic [4:0] wait_cnt;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_cnt   <= '0;
			sync_pulse <= 1'b0;
		end else begin
			sync_pulse <= wait_cnt == 5'h01;
			if (fire)
				wait_cnt <= {1'b0, delay} + 5'h01;
			else if (wait_cnt != 5'h00)
				wait_cnt <= wait_cnt - 5'h01;
		end
	end
endmodule

// File: ptb_timebase.sv
// time-base counter with period shadow, phase sync and apb register access
//
// ==========================================================================
// Overview of operation
// - up-down counts zero to period and back
// - up mode counts zero to period, wraps
// - down mode counts period to zero, reloads
// - frozen mode holds counter value unless a phase sync loads it
// - load select zero routes period to shadow
// - shadow period copied to active at zero
// - shadow mode enabled after reset
// - load select one routes period to active
// - sync loads phase on next tick
// - software sync ORed with sync input
// - up-down sync sets direction, one means up
// - direction setting ignored outside up-down
// - phase disabled ignores sync, still passes through
// - one sync input and one sync output
// - gate low stops clocks, high starts aligned
// - each step takes one time-base period
// - direction output high counting up
// - zero and period events on equality
// - maximum value flagged as status only
`timescale 1ns/1ps
`include "ptb_defs.svh"
module ptb_timebase #(
	parameter int CNT_WIDTH = 16,
	parameter int PSC_WIDTH = 8
) (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire logic                 sync_in,
	output logic                      sync_out,
	output logic      [CNT_WIDTH-1:0] count_value,
	output logic                      count_direction,
	output logic                      count_at_max,
	output logic                      event_zero,
	output logic                      event_period,
	output logic                      timebase_tick
);
	import ptb_pkg::*;

	// ==========================================================================
	// state
	ptb_mode_t            mode;
	logic                 phase_load_enable;
	logic                 period_load_select;
	logic                 sync_direction;
	logic                 sync_out_enable;
	logic [PSC_WIDTH-1:0] prescale;
	logic                 global_clock_gate;
	logic [CNT_WIDTH-1:0] phase_register;
	logic [CNT_WIDTH-1:0] period_active;
	logic [CNT_WIDTH-1:0] period_shadow;
	logic                 sync_pending;
	logic                 count_up;
	logic                 max_seen;

	// ==========================================================================
	// apb decode
	wire access    = psel && penable;
	wire wr        = access && pwrite;
	wire sel_ctl   = (paddr == `PTB_OFS_CONTROL);
	wire sel_sts   = (paddr == `PTB_OFS_STATUS);
	wire sel_phs   = (paddr == `PTB_OFS_PHASE);
	wire sel_cnt   = (paddr == `PTB_OFS_COUNT);
	wire sel_prd   = (paddr == `PTB_OFS_PERIOD);
	wire sel_gate  = (paddr == `PTB_OFS_GATE);
	wire mapped    = sel_ctl | sel_sts | sel_phs | sel_cnt | sel_prd | sel_gate;
	wire wr_ctl    = wr && sel_ctl;
	wire wr_phs    = wr && sel_phs;
	wire wr_cnt    = wr && sel_cnt;
	wire wr_prd    = wr && sel_prd;
	wire wr_gate   = wr && sel_gate;
	wire wr_sts    = wr && sel_sts;
	wire sw_sync   = wr_ctl && pwdata[`PTB_CTL_SWSYNC_BIT];

	assign pready  = 1'b1;
	assign pslverr = access && !mapped;

	// ==========================================================================
	// sync path
	wire sync_event = sync_in || sw_sync;
	assign sync_out = sync_out_enable && sync_event;

	// ==========================================================================
	// prescaler
	wire tick;
	ptb_prescaler #(
		.WIDTH            (PSC_WIDTH)
	) u_prescaler (
		.clk              (clk),
		.rst_n            (rst_n),
		.run              (global_clock_gate),
		.divide_minus_one (prescale),
		.tick             (tick)
	);
	assign timebase_tick = tick;

	// ==========================================================================
	// counter next-state
	wire at_zero   = (count_value == '0);
	wire at_period = (count_value == period_active);
	wire do_sync   = (sync_pending || sync_event) && phase_load_enable;

	logic [CNT_WIDTH-1:0] next_count;
	logic                 next_up;

	always_comb begin
		next_count = count_value;
		next_up    = count_up;
		if (do_sync) begin
			next_count = phase_register;
			if (mode == PTB_MODE_UPDOWN) begin
				next_up = sync_direction;
			end else begin
				next_up = (mode != PTB_MODE_DOWN);
			end
		end else begin
			case (mode)
				PTB_MODE_UP: begin
					next_up    = 1'b1;
					next_count = at_period ? '0 : count_value + 1'b1;
				end
				PTB_MODE_DOWN: begin
					next_up    = 1'b0;
					next_count = at_zero ? period_active : count_value - 1'b1;
				end
				PTB_MODE_UPDOWN: begin
					if (count_up) begin
						if (at_period) begin
							next_up    = at_zero;
							next_count = at_zero ? count_value : count_value - 1'b1;
						end else begin
							next_count = count_value + 1'b1;
						end
					end else begin
						if (at_zero) begin
							next_up    = 1'b1;
							next_count = at_period ? count_value : count_value + 1'b1;
						end else begin
							next_count = count_value - 1'b1;
						end
					end
				end
				PTB_MODE_FREEZE: begin
					next_count = count_value;
				end
				default: begin
					next_count = count_value;
				end
			endcase
		end
	end

	// ==========================================================================
	// control register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode               <= PTB_MODE_FREEZE;
			phase_load_enable  <= 1'b0;
			period_load_select <= 1'b0;
			sync_direction     <= 1'b0;
			sync_out_enable    <= 1'b0;
			prescale           <= '0;
		end else if (wr_ctl) begin
			mode               <= ptb_mode_t'(pwdata[`PTB_CTL_MODE_MSB:`PTB_CTL_MODE_LSB]);
			phase_load_enable  <= pwdata[`PTB_CTL_PHEN_BIT];
			period_load_select <= pwdata[`PTB_CTL_PERIOD_LOAD_SELECT_BIT];
			sync_direction     <= pwdata[`PTB_CTL_DIR_BIT];
			sync_out_enable    <= pwdata[`PTB_CTL_SYNCO_BIT];
			prescale           <= pwdata[`PTB_CTL_PSC_MSB:`PTB_CTL_PSC_LSB];
		end
	end

	// ==========================================================================
	// gate, phase
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			global_clock_gate <= 1'b0;
			phase_register    <= `PTB_PHASE_RESET;
		end else begin
			if (wr_gate) begin
				global_clock_gate <= pwdata[0];
			end
			if (wr_phs) begin
				phase_register <= pwdata[CNT_WIDTH-1:0];
			end
		end
	end

	// ==========================================================================
	// period active and shadow
	wire load_shadow = tick && at_zero && !period_load_select;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			period_shadow <= `PTB_PERIOD_RESET;
			period_active <= `PTB_PERIOD_RESET;
		end else begin
			if (wr_prd && !period_load_select) begin
				period_shadow <= pwdata[CNT_WIDTH-1:0];
			end
			if (wr_prd && period_load_select) begin
				period_active <= pwdata[CNT_WIDTH-1:0];
			end else if (load_shadow) begin
				period_active <= period_shadow;
			end
		end
	end

	// ==========================================================================
	// counter, sync hold until next tick, max flag
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_value  <= '0;
			count_up     <= 1'b1;
			sync_pending <= 1'b0;
			max_seen     <= 1'b0;
		end else begin
			if (wr_cnt) begin
				count_value <= pwdata[CNT_WIDTH-1:0];
			end else if (tick) begin
				count_value <= next_count;
				count_up    <= next_up;
			end
			if (tick) begin
				sync_pending <= 1'b0;
			end else if (sync_event && phase_load_enable) begin
				sync_pending <= 1'b1;
			end
			if (count_value == `PTB_COUNT_MAX) begin
				max_seen <= 1'b1;
			end else if (wr_sts && pwdata[`PTB_STS_MAX_BIT]) begin
				max_seen <= 1'b0;
			end
		end
	end

	// ==========================================================================
	// status outputs
	assign count_direction = count_up;
	assign count_at_max    = max_seen;
	assign event_zero      = at_zero;
	assign event_period    = at_period;

	// ==========================================================================
	// read mux
	wire [31:0] rd_ctl = {16'h0000, prescale, sync_out_enable, 1'b0, sync_direction, 1'b0,
		period_load_select, phase_load_enable, mode};
	wire [31:0] rd_sts = {28'h0000000, event_period, event_zero, max_seen, count_up};
	wire [CNT_WIDTH-1:0] rd_prd = period_load_select ? period_active : period_shadow;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata <= sel_ctl  ? rd_ctl :
			          sel_sts  ? rd_sts :
			          sel_phs  ? {16'h0000, phase_register} :
			          sel_cnt  ? {16'h0000, count_value} :
			          sel_prd  ? {16'h0000, rd_prd} :
			          sel_gate ? {31'h00000000, global_clock_gate} : 32'h0000_0000;
		end
	end

endmodule

// File: ptb_timebase_checker.sv
// port assertions for the time-base counter
`timescale 1ns/1ps
`include "ptb_defs.svh"
module ptb_timebase_checker #(
	parameter int CNT_WIDTH = 16,
	parameter int PSC_WIDTH = 8
) (
	input wire logic                 clk,
	input wire logic                 rst_n,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [11:0]          paddr,
	input wire logic [31:0]          pwdata,
	input wire logic [31:0]          prdata,
	input wire logic                 pready,
	input wire logic                 pslverr,
	input wire logic                 sync_in,
	input wire logic                 sync_out,
	input wire logic [CNT_WIDTH-1:0] count_value,
	input wire logic                 count_direction,
	input wire logic                 count_at_max,
	input wire logic                 event_zero,
	input wire logic                 event_period,
	input wire logic                 timebase_tick
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ==========================================================================
	// bus decode
	wire acc      = psel && penable;
	wire rd_setup = psel && !penable && !pwrite;
	wire cnt_wr   = acc && pwrite && paddr == `PTB_OFS_COUNT;
	wire sw_wr    = acc && pwrite && paddr == `PTB_OFS_CONTROL && pwdata[`PTB_CTL_SWSYNC_BIT];
	wire max_clr  = acc && pwrite && paddr == `PTB_OFS_STATUS && pwdata[`PTB_STS_MAX_BIT];
	// ==========================================================================
	// assertions
	zero_event_a: assert property (event_zero == (count_value == '0)) else $error("zero event wrong");
	step_on_tick_a: assert property (!timebase_tick && !cnt_wr |=> $stable(count_value))
		else $error("count moved without tick");
	max_flag_set_a: assert property (count_value == `PTB_COUNT_MAX |=> count_at_max)
		else $error("max flag not set");
	max_flag_hold_a: assert property (count_at_max && !max_clr |=> count_at_max)
		else $error("max flag lost");
	sync_out_cause_a: assert property (sync_out |-> sync_in || sw_wr)
		else $error("sync out without cause");
	count_read_a: assert property (rd_setup && paddr == `PTB_OFS_COUNT |=> prdata == {16'h0000, $past(count_value)})
		else $error("count read wrong");
	sw_sync_zero_a: assert property (rd_setup && paddr == `PTB_OFS_CONTROL |=> !prdata[`PTB_CTL_SWSYNC_BIT])
		else $error("software sync reads one");
	reset_state_a: assert property ($rose(rst_n) |-> count_value == '0 && count_direction)
		else $error("reset state wrong");
	apb_ready_a: assert property (psel |-> pready) else $error("no ready");
	unmapped_err_a: assert property (acc && paddr > `PTB_OFS_GATE |-> pslverr) else $error("no slave error");
	cover property (sync_out);
	cover property (count_at_max);
	cover property (event_period && !event_zero);
endmodule

// File: ptb_timebase_tb.sv
// testbench of the time-base counter with a reference model
`timescale 1ns/1ps
`include "ptb_defs.svh"
module ptb_timebase_tb;
	import ptb_pkg::*;
	logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, fire = 0, err;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, rd, prdata;
	logic [3:0]  delay = '0;
	logic        pready, pslverr, sync_in, sync_out, count_direction, count_at_max;
	logic        event_zero, event_period, timebase_tick;
	logic [15:0] count_value;
	logic [31:0] m_ctl = 32'h3, tbl [6] = '{32'h88, 32'h9, 32'h2E, 32'h4E, 32'h4C, 32'h6D};
	int          num_errors = 0, checked = 0, cycles = 0, nsync = 0, ntick = 0, t0, p, ph;
	int          m_cnt = 0, m_act = 0, m_sh = 0, m_ph = 0, m_dir = 1, m_gate = 0, m_pend = 0;
	ptb_timebase uut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.sync_in, .sync_out, .count_value, .count_direction, .count_at_max, .event_zero, .event_period,
		.timebase_tick);
	ptb_sync_peer peer (.clk, .rst_n, .fire, .delay, .sync_pulse(sync_in));
	always #5 clk = ~clk;
	// ==========================================================================
	// tasks
	task automatic report_and_stop();
		if (num_errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic cmp_word(logic [31:0] got, logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cmp_bit(logic got, logic exp);
		cmp_word({31'h0, got}, {31'h0, exp});
	endtask
	task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		@(posedge clk);
		while (!pready) @(posedge clk);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic step();
		int z;
		z = (m_cnt == 0);
		if (m_pend) begin
			m_cnt = m_ph;
			if (m_ctl[1:0] == PTB_MODE_UPDOWN)
				m_dir = m_ctl[5];
			else
				m_dir = (m_ctl[1:0] != PTB_MODE_DOWN);
			m_pend = 0;
		end else case (m_ctl[1:0])
			PTB_MODE_UP: begin
				m_dir = 1;
				m_cnt = m_cnt == m_act ? 0 : m_cnt + 1;
			end
			PTB_MODE_DOWN: begin
				m_dir = 0;
				m_cnt = m_cnt == 0 ? m_act : m_cnt - 1;
			end
			PTB_MODE_UPDOWN: begin
				if (m_cnt == m_act)
					m_dir = 0;
				else if (m_cnt == 0)
					m_dir = 1;
				if (m_act != 0)
					m_cnt = m_dir ? m_cnt + 1 : m_cnt - 1;
			end
			default: ;
		endcase
		if (!m_ctl[3] && z)
			m_act = m_sh;
	endtask
	task automatic bus_write(logic [11:0] a, logic [31:0] d);
		case (a)
			`PTB_OFS_CONTROL: m_ctl = d;
			`PTB_OFS_PHASE: m_ph = d[15:0];
			`PTB_OFS_COUNT: m_cnt = d[15:0];
			`PTB_OFS_PERIOD: begin
				if (m_ctl[3])
					m_act = d[15:0];
				else
					m_sh = d[15:0];
			end
			`PTB_OFS_GATE: m_gate = d[0];
			default: ;
		endcase
	endtask
	// ==========================================================================
	// reference model and timeout
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			report_and_stop();
		end
		nsync += sync_out;
		ntick += timebase_tick;
		if (rst_n) begin
			cmp_word(count_value, m_cnt);
			cmp_bit(event_zero, m_cnt == 0);
			cmp_bit(event_period, m_cnt == m_act);
			if (m_cnt > 0 && m_cnt < m_act)
				cmp_bit(count_direction, m_dir[0]);
			if (!m_gate)
				cmp_bit(timebase_tick, 0);
			if (m_ctl[2] && sync_in)
				m_pend = 1;
			if (m_ctl[2] && psel && penable && pwrite && paddr == `PTB_OFS_CONTROL && pwdata[6])
				m_pend = 1;
			if (timebase_tick)
				step();
			if (psel && penable && pwrite)
				bus_write(paddr, pwdata);
		end
	end
	// ==========================================================================
	// scenarios
	initial begin
		t0 = $urandom(32'h9d59);
		repeat (5) @(posedge clk);
		rst_n <= 1;
		apb(0, `PTB_OFS_CONTROL, 0);
		cmp_word(rd, `PTB_CTL_RESET);
		apb(0, `PTB_OFS_GATE, 0);
		cmp_word(rd, 0);
		apb(0, 12'h020, 0);
		cmp_word({rd[30:0], err}, 1);
		apb(1, `PTB_OFS_PERIOD, 5);
		apb(0, `PTB_OFS_PERIOD, 0);
		cmp_word(rd, 5);
		apb(1, `PTB_OFS_GATE, 0);
		apb(1, `PTB_OFS_CONTROL, 0);
		repeat (10) @(posedge clk);
		apb(1, `PTB_OFS_GATE, 1);
		repeat (30) @(posedge clk);
		p = 6 + $urandom % 10;
		ph = 1 + $urandom % (p - 1);
		apb(1, `PTB_OFS_CONTROL, 32'h8);
		apb(1, `PTB_OFS_PERIOD, p);
		apb(1, `PTB_OFS_PHASE, ph);
		foreach (tbl[i]) begin
			apb(1, `PTB_OFS_CONTROL, tbl[i]);
			repeat (25) @(posedge clk);
			delay <= $urandom % 4;
			fire <= 1;
			@(posedge clk);
			fire <= 0;
			repeat (25) @(posedge clk);
		end
		apb(1, `PTB_OFS_CONTROL, 32'h3);
		apb(1, `PTB_OFS_COUNT, 32'hFFFF);
		repeat (3) @(negedge clk);
		cmp_bit(count_at_max, 1);
		apb(0, `PTB_OFS_COUNT, 0);
		cmp_word(rd, 32'hFFFF);
		apb(1, `PTB_OFS_COUNT, 0);
		apb(1, `PTB_OFS_STATUS, 2);
		@(negedge clk);
		cmp_bit(count_at_max, 0);
		apb(1, `PTB_OFS_CONTROL, 32'h308);
		@(negedge clk);
		t0 = ntick;
		repeat (40) @(negedge clk);
		cmp_word(ntick - t0, 10);
		cmp_word(nsync, 1);
		report_and_stop();
	end
endmodule
bind ptb_timebase ptb_timebase_checker #(.CNT_WIDTH(CNT_WIDTH), .PSC_WIDTH(PSC_WIDTH)) chk (.clk, .rst_n, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sync_in, .sync_out, .count_value,
	.count_direction, .count_at_max, .event_zero, .event_period, .timebase_tick);
